//--- fifo_far_side.sv
// Far-side model: upstream writer, downstream reader, offset programmer.
// Assumes the bench clock; driven pin levels are held four clk_in cycles, the serial clock high level five.
`timescale 1ns/1ps
`default_nettype none

module fifo_far_side (
    // Clock
    input  wire logic                       clk_in,
    // Pins toward the FIFO
    output wire four_queue_fifo_pkg::pins_s pins_out
);
    import four_queue_fifo_pkg::*;
    pins_s p;
    assign pins_out = p;

    // ==========================================================
    // Idle levels
    initial
    begin
        p = '0;
        {p.wen_n, p.wcs_n, p.ren_n, p.rcs_n, p.offset_serial_load_n_n, p.offset_serial_readback_n_n} = 6'h3f;
    end

    // ==========================================================
    // Port edges, pins held past the sampling window
    task automatic wedge(input logic [1:0] q, input logic [DATA_W-1:0] d,
                         input logic en_n, input logic cs_n);
        {p.wsel, p.din, p.wen_n, p.wcs_n} <= {q, d, en_n, cs_n};
        p.wclk <= ~p.wclk;
        repeat (4) @(posedge clk_in);
        {p.din, p.wen_n, p.wcs_n} <= {~d, 2'h3};
        @(posedge clk_in);
    endtask : wedge

    task automatic redge(input logic [1:0] q, input logic cs_n);
        {p.rsel, p.ren_n, p.rcs_n} <= {q, 1'b0, cs_n};
        p.rclk <= ~p.rclk;
        repeat (4) @(posedge clk_in);
        {p.ren_n, p.rcs_n} <= 2'h3;
        @(posedge clk_in);
    endtask : redge

    // Serial clock stands low between bits
    task automatic sbit(input logic ld_n, input logic rb_n, input logic b);
        {p.offset_serial_load_n_n, p.offset_serial_readback_n_n, p.si} <= {ld_n, rb_n, b};
        repeat (4) @(posedge clk_in);
        p.sclk <= 1'b1;
        repeat (5) @(posedge clk_in);
        {p.si, p.sclk} <= {~b, 1'b0};
        repeat (4) @(posedge clk_in);
    endtask : sbit

endmodule : fifo_far_side

`default_nettype wire

//--- four_queue_ddr_fifo_ports.sv
// Four-queue FIFO with independent write, read and serial offset ports.
// Assumes all port clocks are slow pins sampled against clk_in.
`timescale 1ns/1ps
`default_nettype none

module four_queue_ddr_fifo_ports
    import four_queue_fifo_pkg::*;
#(
    parameter int DEPTH_UNITS = 64
)(
    // Clock and reset
    input  wire logic                                   clk_in,
    input  wire logic                                   rst_n_in,
    // Configuration and control pins
    input  wire logic                                   master_reset_n_in,
    input  wire logic                                   power_down_n_in,
    input  wire logic [four_queue_fifo_pkg::QUEUES-1:0] queue_partial_reset_n_in,
    input  wire logic [1:0]                             default_offset_choice_in,
    input  wire logic [1:0]                             write_width_cfg_in,
    input  wire logic [1:0]                             read_width_cfg_in,
    input  wire logic                                   write_double_rate_in,
    input  wire logic                                   read_double_rate_in,
    // Write port
    input  wire logic                                   write_clock_in,
    input  wire logic                                   write_enable_n_in,
    input  wire logic                                   write_chip_select_n_in,
    input  wire logic [1:0]                             write_queue_sel_in,
    input  wire logic [four_queue_fifo_pkg::DATA_W-1:0] write_data_in,
    // Read port
    input  wire logic                                   read_clock_in,
    input  wire logic                                   read_enable_n_in,
    input  wire logic                                   read_chip_select_n_in,
    input  wire logic                                   output_enable_n_in,
    input  wire logic [1:0]                             read_queue_sel_in,
    output logic      [four_queue_fifo_pkg::DATA_W-1:0] read_data_out,
    output logic                                        read_data_oe_n_out,
    output logic                                        echo_read_clock_out,
    output logic                                        echo_read_valid_n_out,
    // Serial offset port
    input  wire logic                                   serial_clock_in,
    input  wire logic                                   fallthrough_or_serial_in,
    input  wire logic                                   offset_serial_load_n_in,
    input  wire logic                                   offset_serial_readback_n_in,
    output logic                                        offset_serial_out,
    // Flags, active low
    output logic      [four_queue_fifo_pkg::QUEUES-1:0] queue_drain_flag_n_out,
    output logic      [four_queue_fifo_pkg::QUEUES-1:0] queue_fill_flag_n_out,
    output logic      [four_queue_fifo_pkg::QUEUES-1:0] almost_empty_flag_n_out,
    output logic      [four_queue_fifo_pkg::QUEUES-1:0] almost_full_flag_n_out,
    output logic                                        read_side_empty_summary_n_out,
    output logic                                        write_side_full_summary_n_out
);
    import four_queue_fifo_pkg::*;

    localparam int PW = $clog2(DEPTH_UNITS);
    localparam int CW = PW + 1;
    localparam int FW = (CW > OFF_W) ? CW : OFF_W;
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH_UNITS);

    initial
    begin
        if (DEPTH_UNITS < 2 * UNITS_MAX || (1 << PW) != DEPTH_UNITS)
            $error("DEPTH_UNITS must be a power of two of at least 8");
    end

    // ================================================================
    // Pin synchronisers
    pins_s pin_raw;
    pins_s s1;
    pins_s s2;
    pins_s s3;

    assign pin_raw = '{wclk: write_clock_in, rclk: read_clock_in, sclk: serial_clock_in,
                       mrs_n: master_reset_n_in, wen_n: write_enable_n_in,
                       wcs_n: write_chip_select_n_in, ren_n: read_enable_n_in,
                       rcs_n: read_chip_select_n_in, offset_serial_load_n_n: offset_serial_load_n_in,
                       offset_serial_readback_n_n: offset_serial_readback_n_in, si: fallthrough_or_serial_in,
                       pd_n: power_down_n_in, prs_n: queue_partial_reset_n_in,
                       wsel: write_queue_sel_in, rsel: read_queue_sel_in,
                       default_offset_choice: default_offset_choice_in, iw: write_width_cfg_in,
                       ow: read_width_cfg_in, write_double_rate: write_double_rate_in,
                       read_double_rate: read_double_rate_in, din: write_data_in};

    always_ff @(posedge clk_in)
    begin
        s1 <= pin_raw;
        s2 <= s1;
        s3 <= s2;
    end

    // Port clock levels count once second and third stages agree
    logic [2:0] clk_seen;
    wire  [2:0] clk_now   = {s3.wclk, s3.rclk, s3.sclk};
    wire  [2:0] clk_agree = ~({s2.wclk, s2.rclk, s2.sclk} ^ clk_now);
    wire  [2:0] clk_move  = clk_agree & (clk_now ^ clk_seen);

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            clk_seen <= '0;
        else
            clk_seen <= (clk_now & clk_agree) | (clk_seen & ~clk_agree);
    end

    // ================================================================
    // Configuration and offsets
    cfg_s               cfg;
    logic [CHAIN_W-1:0] chain;
    logic [CHAIN_W-1:0] readback;
    logic               offset_serial_readback_n_prev;
    logic [OFF_W-1:0]   default_off;

    wire in_mrs = ~s3.mrs_n;
    wire live   = s3.mrs_n & s3.pd_n;
    wire s_rise = clk_move[0] & s3.sclk & live;

    assign default_off = (s3.default_offset_choice == 2'h0) ? OFFSET_SEL0 :
                         (s3.default_offset_choice == 2'h1) ? OFFSET_SEL1 :
                         (s3.default_offset_choice == 2'h2) ? OFFSET_SEL2 : OFFSET_SEL3;

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            cfg   <= CFG_RESET;
            chain <= {2 * QUEUES{OFFSET_SEL0}};
        end
        else if (in_mrs)
        begin
            cfg   <= '{fwft: s3.si, write_double_rate: s3.write_double_rate, read_double_rate: s3.read_double_rate,
                       iw: s3.iw, ow: s3.ow};
            chain <= {2 * QUEUES{default_off}};
        end
        else if (s_rise && !s3.offset_serial_load_n_n)
            chain <= {chain[CHAIN_W-2:0], s3.si};
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in || in_mrs)
        begin
            readback          <= '0;
            offset_serial_readback_n_prev         <= 1'b1;
            offset_serial_out <= 1'b0;
        end
        else if (s_rise)
        begin
            offset_serial_readback_n_prev <= s3.offset_serial_readback_n_n;
            if (!s3.offset_serial_readback_n_n && offset_serial_readback_n_prev)
            begin
                offset_serial_out <= chain[CHAIN_W-1];
                readback          <= {chain[CHAIN_W-2:0], 1'b0};
            end
            else if (!s3.offset_serial_readback_n_n)
            begin
                offset_serial_out <= readback[CHAIN_W-1];
                readback          <= {readback[CHAIN_W-2:0], 1'b0};
            end
        end
    end

    // ================================================================
    // Port strobes
    logic [CW-1:0] in_units;
    logic [CW-1:0] out_units;
    logic [1:0]    in_shift;
    logic [1:0]    out_shift;

    assign in_shift  = (cfg.iw > WIDTH_X40) ? WIDTH_X40 : cfg.iw;
    assign out_shift = (cfg.ow > WIDTH_X40) ? WIDTH_X40 : cfg.ow;
    assign in_units  = CW'(1) << in_shift;
    assign out_units = CW'(1) << out_shift;

    logic [QUEUES-1:0] full;
    logic [QUEUES-1:0] avail;
    logic [PW-1:0]     wp [QUEUES];
    logic [PW-1:0]     rp [QUEUES];
    logic [CW-1:0]     cnt [QUEUES];
    logic [UNIT_W-1:0] mem [QUEUES][DEPTH_UNITS];

    wire w_edge = clk_move[2] & (s3.wclk | cfg.write_double_rate);
    wire r_edge = clk_move[1] & (s3.rclk | cfg.read_double_rate);
    wire wr_go  = live & w_edge & ~s3.wen_n & ~s3.wcs_n & ~full[s3.wsel];
    wire rd_go  = live & r_edge & ~s3.ren_n & ~s3.rcs_n & avail[s3.rsel];

    logic [DATA_W-1:0] next_rd_word;

    always_comb
    begin
        next_rd_word = '0;
        for (int k = 0; k < UNITS_MAX; k++)
            if (CW'(k) < out_units)
                next_rd_word[k*UNIT_W +: UNIT_W] =
                    mem[s3.rsel][rp[s3.rsel] + PW'(k)];
    end

    always_ff @(posedge clk_in)
    begin
        if (wr_go)
            for (int k = 0; k < UNITS_MAX; k++)
                if (CW'(k) < in_units)
                    mem[s3.wsel][wp[s3.wsel] + PW'(k)] <= s3.din[k*UNIT_W +: UNIT_W];
    end

    // ================================================================
    // Per-queue pointers and flags
    logic [QUEUES-1:0] next_drain;
    logic [QUEUES-1:0] next_fill;

    generate
        for (genvar q = 0; q < QUEUES; q++)
        begin : g_queue
            wire           wr_hit = wr_go && s3.wsel == 2'(q);
            wire           rd_hit = rd_go && s3.rsel == 2'(q);
            wire [OFF_W-1:0] ae_off = chain[2*q*OFF_W +: OFF_W];
            wire [OFF_W-1:0] af_off = chain[(2*q+1)*OFF_W +: OFF_W];
            wire [CW-1:0]  cnt_nx = cnt[q] + (wr_hit ? in_units : '0)
                                           - (rd_hit ? out_units : '0);
            wire           full_nx  = cnt_nx > DEPTH_C - in_units;
            wire           avail_nx = cnt_nx >= out_units;

            assign next_drain[q] = cfg.fwft ? ~avail_nx : avail_nx;
            assign next_fill[q]  = cfg.fwft ? full_nx : ~full_nx;

            always_ff @(posedge clk_in)
            begin
                if (!rst_n_in || in_mrs || !s3.prs_n[q])
                begin
                    wp[q]    <= '0;
                    rp[q]    <= '0;
                    cnt[q]   <= '0;
                    full[q]  <= 1'b0;
                    avail[q] <= 1'b0;
                    almost_empty_flag_n_out[q] <= 1'b0;
                    almost_full_flag_n_out[q]  <= 1'b1;
                end
                else
                begin
                    if (wr_hit)
                        wp[q] <= wp[q] + in_units[PW-1:0];
                    if (rd_hit)
                        rp[q] <= rp[q] + out_units[PW-1:0];
                    cnt[q]   <= cnt_nx;
                    full[q]  <= full_nx;
                    avail[q] <= avail_nx;
                    almost_empty_flag_n_out[q] <=
                        (FW'(cnt_nx >> out_shift) > FW'(ae_off));
                    almost_full_flag_n_out[q]  <=
                        (FW'((DEPTH_C - cnt_nx) >> in_shift) > FW'(af_off));
                end
            end
        end
    endgenerate

    // ================================================================
    // Output registers
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in || in_mrs)
        begin
            queue_drain_flag_n_out        <= '0;
            queue_fill_flag_n_out         <= '1;
            read_side_empty_summary_n_out <= 1'b0;
            write_side_full_summary_n_out <= 1'b1;
            read_data_out                 <= '0;
            echo_read_valid_n_out         <= 1'b1;
            echo_read_clock_out           <= 1'b0;
        end
        else
        begin
            queue_drain_flag_n_out        <= next_drain;
            queue_fill_flag_n_out         <= next_fill;
            read_side_empty_summary_n_out <= next_drain[s3.rsel];
            write_side_full_summary_n_out <= next_fill[s3.wsel];
            echo_read_clock_out           <= s3.rclk;
            echo_read_valid_n_out         <= ~rd_go;
            if (!s3.prs_n[s3.rsel])
                read_data_out <= '0;
            else if (rd_go)
                read_data_out <= next_rd_word;
        end
    end

    // Float path must not wait for any clock
    assign read_data_oe_n_out = output_enable_n_in | read_chip_select_n_in;

    // ================================================================
    // Assertions
    property p_read_summary;
        @(posedge clk_in) disable iff (!rst_n_in)
        $past(rst_n_in) && s3.mrs_n |=> read_side_empty_summary_n_out ==
            queue_drain_flag_n_out[$past(s3.rsel)];
    endproperty
    a_read_summary: assert property (p_read_summary) else $error("read summary mismatch");

    property p_write_summary;
        @(posedge clk_in) disable iff (!rst_n_in)
        $past(rst_n_in) && s3.mrs_n |=> write_side_full_summary_n_out ==
            queue_fill_flag_n_out[$past(s3.wsel)];
    endproperty
    a_write_summary: assert property (p_write_summary) else $error("write summary mismatch");

    property p_write_advance;
        @(posedge clk_in) disable iff (!rst_n_in)
        wr_go && s3.wsel == 2'h0 && s3.prs_n[0] |=> wp[0] == $past(wp[0]) + $past(in_units[PW-1:0]);
    endproperty
    a_write_advance: assert property (p_write_advance) else $error("write pointer stuck");

    property p_echo_valid;
        @(posedge clk_in) disable iff (!rst_n_in || in_mrs)
        rd_go |=> !echo_read_valid_n_out ##1 ($past(rd_go) == !echo_read_valid_n_out);
    endproperty
    a_echo_valid: assert property (p_echo_valid) else $error("echo valid wrong");

    property p_default_offset;
        @(posedge clk_in) disable iff (!rst_n_in)
        in_mrs |=> chain[OFF_W-1:0] == $past(default_off) && chain[CHAIN_W-1 -: OFF_W] == $past(default_off);
    endproperty
    a_default_offset: assert property (p_default_offset) else $error("default offset not loaded");

    property p_partial_reset;
        @(posedge clk_in) disable iff (!rst_n_in)
        !s3.prs_n[0] |=> cnt[0] == '0 && wp[0] == '0 && rp[0] == '0;
    endproperty
    a_partial_reset: assert property (p_partial_reset) else $error("partial reset missed");

    property p_chip_select;
        @(posedge clk_in) disable iff (!rst_n_in)
        s3.rcs_n && s3.mrs_n && s3.prs_n[s3.rsel] |=>
            echo_read_valid_n_out && $stable(read_data_out);
    endproperty
    a_chip_select: assert property (p_chip_select) else $error("read while deselected");

    property p_serial_load;
        @(posedge clk_in) disable iff (!rst_n_in)
        s_rise && !s3.offset_serial_load_n_n |=> chain[0] == $past(s3.si) && chain[OFF_W-1:1] == $past(chain[OFF_W-2:0]);
    endproperty
    a_serial_load: assert property (p_serial_load) else $error("serial load failed");

    property p_output_float;
        @(posedge clk_in) disable iff (!rst_n_in)
        output_enable_n_in |-> read_data_oe_n_out;
    endproperty
    a_output_float: assert property (p_output_float) else $error("outputs not floated");

endmodule : four_queue_ddr_fifo_ports

`default_nettype wire

//--- four_queue_fifo_pkg.sv
// Shared constants and carrier types for the four-queue flow-control FIFO.
// Assumes a single system clock; pin activity is sampled on that clock, apart from the combinational output float path.
package four_queue_fifo_pkg;

    // ================================================================
    // Geometry
    localparam int QUEUES      = 4;
    localparam int UNIT_W      = 10;
    localparam int DATA_W      = 40;
    localparam int UNITS_MAX   = 4;
    localparam int OFF_W       = 10;
    localparam int CHAIN_W     = 2 * QUEUES * OFF_W;
    localparam int SYNC_STAGES = 3;

    // ================================================================
    // Default offsets chosen at master reset
    localparam logic [OFF_W-1:0] OFFSET_SEL0 = 10'h007;
    localparam logic [OFF_W-1:0] OFFSET_SEL1 = 10'h03f;
    localparam logic [OFF_W-1:0] OFFSET_SEL2 = 10'h07f;
    localparam logic [OFF_W-1:0] OFFSET_SEL3 = 10'h3ff;

    // ================================================================
    // Width codes
    localparam logic [1:0] WIDTH_X10 = 2'h0;
    localparam logic [1:0] WIDTH_X20 = 2'h1;
    localparam logic [1:0] WIDTH_X40 = 2'h2;

    typedef struct packed {
        logic       fwft;
        logic       write_double_rate;
        logic       read_double_rate;
        logic [1:0] iw;
        logic [1:0] ow;
    } cfg_s;

    localparam cfg_s CFG_RESET = '{fwft: 1'b0, write_double_rate: 1'b0, read_double_rate: 1'b0,
                                   iw: WIDTH_X40, ow: WIDTH_X40};

    typedef struct packed {
        logic              wclk;
        logic              rclk;
        logic              sclk;
        logic              mrs_n;
        logic              wen_n;
        logic              wcs_n;
        logic              ren_n;
        logic              rcs_n;
        logic              offset_serial_load_n_n;
        logic              offset_serial_readback_n_n;
        logic              si;
        logic              pd_n;
        logic [QUEUES-1:0] prs_n;
        logic [1:0]        wsel;
        logic [1:0]        rsel;
        logic [1:0]        default_offset_choice;
        logic [1:0]        iw;
        logic [1:0]        ow;
        logic              write_double_rate;
        logic              read_double_rate;
        logic [DATA_W-1:0] din;
    } pins_s;

endpackage : four_queue_fifo_pkg

//--- test_four_queue_ddr_fifo_ports.sv
// Self-checking bench for the four-queue FIFO: corner cases and seeded traffic.
// Assumes fifo_far_side drives the port pins; the bench owns resets and setup.
`timescale 1ns/1ps
`default_nettype none

module test_four_queue_ddr_fifo_ports;
    import four_queue_fifo_pkg::*;
    localparam int CAP = 4;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic oe_n = 1'b0;
    logic ft = 1'b0;
    pins_s c;
    wire pins_s f;
    logic [DATA_W-1:0] q_o, w;
    logic oe_o, ec_o, ev_o, so, es, fs;
    logic [QUEUES-1:0] dr, fl, ae, af;
    logic [79:0] chain, v;
    logic [OFF_W-1:0] off [4] = '{10'h007, 10'h03f, 10'h07f, 10'h3ff};
    int num_errors = 0;
    int samples_checked = 0;
    int echo_seen = 0;
    int seed = 12790;
    int aeo [QUEUES];
    int afo [QUEUES];
    logic [DATA_W-1:0] mq [QUEUES][$];

    always #25 clk_in = ~clk_in;
    always @(negedge clk_in) if (ev_o === 1'b0) echo_seen++;

    // ==========================================================
    // Design and far side; setup owns the shared pin until reset settles
    four_queue_ddr_fifo_ports #(.DEPTH_UNITS(16)) dut_u (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .master_reset_n_in(c.mrs_n),
        .power_down_n_in(c.pd_n), .queue_partial_reset_n_in(c.prs_n),
        .default_offset_choice_in(c.default_offset_choice), .write_width_cfg_in(c.iw),
        .read_width_cfg_in(c.ow), .write_double_rate_in(c.write_double_rate),
        .read_double_rate_in(c.read_double_rate), .write_clock_in(f.wclk),
        .write_enable_n_in(f.wen_n), .write_chip_select_n_in(f.wcs_n),
        .write_queue_sel_in(f.wsel), .write_data_in(f.din), .read_clock_in(f.rclk),
        .read_enable_n_in(f.ren_n), .read_chip_select_n_in(f.rcs_n),
        .output_enable_n_in(oe_n), .read_queue_sel_in(f.rsel), .read_data_out(q_o),
        .read_data_oe_n_out(oe_o), .echo_read_clock_out(ec_o),
        .echo_read_valid_n_out(ev_o), .serial_clock_in(f.sclk),
        .fallthrough_or_serial_in(c.offset_serial_readback_n_n ? c.si : f.si),
        .offset_serial_load_n_in(f.offset_serial_load_n_n), .offset_serial_readback_n_in(f.offset_serial_readback_n_n),
        .offset_serial_out(so), .queue_drain_flag_n_out(dr), .queue_fill_flag_n_out(fl),
        .almost_empty_flag_n_out(ae), .almost_full_flag_n_out(af),
        .read_side_empty_summary_n_out(es), .write_side_full_summary_n_out(fs));
    fifo_far_side far_u (.clk_in(clk_in), .pins_out(f));

    always @(negedge clk_in)
        if (rst_n_in) chk(DATA_W'(oe_o), DATA_W'(oe_n | f.rcs_n));

    // ==========================================================
    // Checking and expectation helpers
    task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
        samples_checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask : chk

    task automatic done(input string s);
        $display("test %s done, errors %0d", s, num_errors);
    endtask : done

    task automatic flags();
        logic [QUEUES-1:0] d, u, e, a;
        for (int i = 0; i < QUEUES; i++)
        begin
            d[i] = (mq[i].size() != 0) ^ ft;
            u[i] = (mq[i].size() != CAP) ^ ft;
            e[i] = mq[i].size() > aeo[i];
            a[i] = CAP - mq[i].size() > afo[i];
        end
        chk(DATA_W'({dr, fl, ae, af}), DATA_W'({d, u, e, a}));
        chk(DATA_W'({es, fs}), DATA_W'({d[f.rsel], u[f.wsel]}));
    endtask : flags

    task automatic mreset(input logic [1:0] default_offset_choice, iw, ow, input logic wd, rdd, fw);
        {c.mrs_n, c.offset_serial_readback_n_n, c.default_offset_choice, c.iw, c.ow, c.write_double_rate, c.read_double_rate, c.si} <=
            {2'h1, default_offset_choice, iw, ow, wd, rdd, fw};
        repeat (6) @(posedge clk_in);
        c.mrs_n <= 1'b1;
        repeat (6) @(posedge clk_in);
        c.offset_serial_readback_n_n <= 1'b0;
        @(posedge clk_in);
        ft = fw;
        chain = {8{off[default_offset_choice]}};
        for (int i = 0; i < QUEUES; i++)
        begin
            mq[i].delete();
            aeo[i] = off[default_offset_choice];
            afo[i] = off[default_offset_choice];
        end
    endtask : mreset

    task automatic wr(input logic [1:0] q, input logic [DATA_W-1:0] d);
        far_u.wedge(q, d, 1'b0, 1'b0);
        far_u.wedge(q, ~d, 1'b0, 1'b0);
        if (mq[q].size() < CAP)
            mq[q].push_back(d);
        flags();
    endtask : wr

    task automatic rstep(input logic [1:0] q, input logic cs_n, input bit vl,
                         input logic [DATA_W-1:0] e);
        int n;
        n = echo_seen;
        far_u.redge(q, cs_n);
        @(posedge clk_in);
        chk(DATA_W'(echo_seen - n), DATA_W'(vl));
        chk(DATA_W'(ec_o), DATA_W'(f.rclk));
        if (vl)
            chk(q_o, e);
    endtask : rstep

    task automatic rd(input logic [1:0] q);
        bit vl;
        vl = mq[q].size() != 0;
        rstep(q, 1'b0, vl, vl ? mq[q][0] : '0);
        if (vl)
            void'(mq[q].pop_front());
        rstep(q, 1'b0, 1'b0, '0);
        flags();
    endtask : rd

    task automatic sload(input logic [79:0] x);
        for (int i = 79; i >= 0; i--)
            far_u.sbit(1'b0, 1'b1, x[i]);
        far_u.sbit(1'b1, 1'b1, 1'b0);
        chain = x;
        for (int i = 0; i < QUEUES; i++)
        begin
            aeo[i] = x[20*i +: 10];
            afo[i] = x[20*i+10 +: 10];
        end
    endtask : sload

    task automatic sread();
        far_u.sbit(1'b1, 1'b1, 1'b0);
        for (int i = 79; i >= 0; i--)
        begin
            far_u.sbit(1'b1, 1'b0, 1'b0);
            chk(DATA_W'(so), DATA_W'(chain[i]));
        end
        far_u.sbit(1'b1, 1'b1, 1'b0);
    endtask : sread

    task automatic end_of_test();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    // ==========================================================
    // Main sequence
    initial
    begin
        c = '0;
        {c.pd_n, c.prs_n, c.offset_serial_readback_n_n} = 6'h3f;
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        for (int s = 0; s < 4; s++)
        begin
            mreset(2'(s), WIDTH_X40, WIDTH_X40, 1'b0, 1'b0, 1'b0);
            flags();
            sread();
        end
        done("default offsets");
        for (int i = 0; i < QUEUES; i++)
            v[20*i +: 20] = {10'($unsigned($random(seed)) % 4), 10'(i)};
        sload(v);
        flags();
        sread();
        for (int k = 0; k < 5; k++)
            wr(2'h2, DATA_W'({$random(seed), $random(seed)}));
        for (int k = 0; k < 5; k++)
            rd(2'h2);
        for (int k = 0; k < 60; k++)
        begin
            oe_n <= 1'($random(seed));
            if ($random(seed) & 1)
                wr(2'($random(seed)), DATA_W'({$random(seed), $random(seed)}));
            else
                rd(2'($random(seed)));
        end
        done("traffic");
        far_u.wedge(2'h1, '1, 1'b1, 1'b0);
        far_u.wedge(2'h1, '1, 1'b1, 1'b1);
        far_u.wedge(2'h1, '1, 1'b0, 1'b1);
        far_u.wedge(2'h1, '1, 1'b1, 1'b1);
        rstep(2'h0, 1'b1, 1'b0, '0);
        rstep(2'h0, 1'b1, 1'b0, '0);
        c.pd_n <= 1'b0;
        repeat (4) @(posedge clk_in);
        far_u.wedge(2'h1, '1, 1'b0, 1'b0);
        far_u.wedge(2'h1, '1, 1'b0, 1'b0);
        c.pd_n <= 1'b1;
        repeat (6) @(posedge clk_in);
        flags();
        wr(2'h1, '1);
        c.prs_n[1] <= 1'b0;
        repeat (5) @(posedge clk_in);
        c.prs_n[1] <= 1'b1;
        repeat (5) @(posedge clk_in);
        mq[1].delete();
        flags();
        sread();
        done("refusals and partial reset");
        mreset(2'h0, WIDTH_X10, WIDTH_X40, 1'b1, 1'b0, 1'b1);
        chk(DATA_W'({dr, fl}), DATA_W'(8'hf0));
        w = DATA_W'({$random(seed), $random(seed)});
        for (int k = 0; k < 4; k++)
            far_u.wedge(2'h3, DATA_W'(w[10*k +: 10]), 1'b0, 1'b0);
        chk(DATA_W'(dr[3]), '0);
        rstep(2'h3, 1'b0, 1'b1, w);
        rstep(2'h3, 1'b0, 1'b0, '0);
        mreset(2'h0, WIDTH_X40, WIDTH_X10, 1'b0, 1'b1, 1'b0);
        wr(2'h0, w);
        for (int k = 0; k < 4; k++)
            rstep(2'h0, 1'b0, 1'b1, DATA_W'(w[10*k +: 10]));
        mq[0].delete();
        flags();
        done("width and rate");
        end_of_test();
    end

    initial
    begin
        repeat (40000) @(posedge clk_in);
        num_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        end_of_test();
    end

endmodule : test_four_queue_ddr_fifo_ports

`default_nettype wire
